// *** rtl/msd_decoder.sv ***
// Operation
// - Program, data and stack spaces stay independent.
// - Twelve-bit program counter reaches 4K program bytes.
// - Stack holds six twelve-bit return addresses.
// - Protection bit refuses external program memory reads.
// - Only full erasure clears protection and memory.
// - Core reads program constants through 64-byte window.
// - One data map holds RAM and registers.
// - 080h-083h pointer and short registers, no reset.
// - Port data registers 0C0h/0C1h reset 00h.
// - Port direction registers 0C4h/0C5h reset 00h.
// - Port option registers 0CCh/0CDh reset 00h.
// - Window select 0C9h write-only, no reset.
// - Converter control 0D1h resets 40h, mixed access.
// - Timer prescaler 0D2h read/write, resets 7Fh.
// - Timer downcounter 0D3h read/write, resets FFh.
// - Timer status/control 0D4h read/write, resets 00h.
// - Port data read returns pins for inputs.
// - Window select low six bits choose block.
`include "msd_defs.svh"

module msd_decoder
	import msd_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire msd_data_req_t i_data_req,
	output logic [7:0] o_data_rdata,
	input wire logic [11:0] i_program_counter,
	output logic [7:0] o_fetch_data,
	input wire logic i_stack_push,
	input wire logic i_stack_pop,
	input wire logic [11:0] i_push_addr,
	output logic [11:0] o_stack_top,
	input wire logic i_prog_we,
	input wire logic [11:0] i_prog_addr,
	input wire logic [7:0] i_prog_wdata,
	input wire logic i_protect_set,
	input wire logic i_full_erase,
	input wire logic i_ext_rd,
	input wire logic [11:0] i_ext_addr,
	output logic [7:0] o_ext_rdata,
	output logic o_ext_refused,
	output logic o_protected,
	input wire logic [7:0] i_port_a_pin,
	input wire logic [7:0] i_port_b_pin,
	output msd_port_out_t o_port_a,
	output msd_port_out_t o_port_b,
	output logic [7:0] o_port_a_option,
	output logic [7:0] o_port_b_option,
	output logic [7:0] o_interrupt_option,
	input wire logic [7:0] i_conv_result,
	input wire logic i_conv_status_we,
	input wire logic [7:0] i_conv_status,
	output logic [7:0] o_conv_control,
	output logic [7:0] o_timer_prescaler,
	output logic [7:0] o_timer_downcounter,
	output logic [7:0] o_timer_status_control,
	output logic [7:0] o_watchdog_reg
);

	// ----------------------------------------
	// Storage
	// ----------------------------------------

	// Program memory, reached only through program-space ports and the window.
	logic [7:0] prog_mem [`MSD_PM_DEPTH];
	// User RAM of the data space.
	logic [7:0] data_ram [`MSD_RAM_DEPTH];
	// Return stack, level 0 is the most recent entry.
	logic [11:0] stack_lvl [`MSD_STACK_LEVELS];
	// Pointer, short direct and accumulator registers.
	logic [7:0] pointer_reg_one;
	logic [7:0] pointer_reg_two;
	logic [7:0] short_direct_one;
	logic [7:0] short_direct_second;
	logic [7:0] accumulator;
	// Write-only window select register.
	logic [7:0] rom_window_select;
	// Readout protection latch.
	logic protect_on;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------

	// Region of the current data-space address.
	msd_region_t region;
	// Index into user RAM.
	logic [5:0] ram_idx;
	// Program address seen through the data window.
	logic [11:0] win_addr;
	// Write strobe of the core.
	logic wr;

	assign wr = i_data_req.wr;
	assign ram_idx = 6'(i_data_req.addr - `MSD_RAM_LO);
	assign win_addr = {rom_window_select[5:0], i_data_req.addr[5:0]};

	// Sorts each data address into window, RAM, hardware register or hole.
	always_comb begin
		if (i_data_req.addr >= `MSD_WIN_LO && i_data_req.addr <= `MSD_WIN_HI) begin
			region = MSD_REG_WINDOW;
		end else if (i_data_req.addr >= `MSD_RAM_LO && i_data_req.addr <= `MSD_RAM_HI) begin
			region = MSD_REG_RAM;
		end else if (i_data_req.addr >= `MSD_PTR_ONE) begin
			region = MSD_REG_HW;
		end else begin
			region = MSD_REG_NONE;
		end
	end

	// ----------------------------------------
	// Program memory and protection
	// ----------------------------------------

	// Programs bytes, and a full erasure blanks every byte in one cycle.
	always_ff @(posedge i_ref_clk) begin
		if (i_full_erase) begin
			for (int i = 0; i < `MSD_PM_DEPTH; i++) begin
				prog_mem[i] <= `MSD_ERASED;
			end
		end else if (i_prog_we) begin
			prog_mem[i_prog_addr] <= i_prog_wdata;
		end
	end

	// The protection latch is set by the option bit and cleared only by erasure.
	// Reset leaves the latch alone, since it stands for a non-volatile option bit.
	// A blank part therefore needs one full erasure before its first use.
	always_ff @(posedge i_ref_clk) begin
		if (i_full_erase) begin
			protect_on <= 1'b0;
		end else if (i_protect_set) begin
			protect_on <= 1'b1;
		end
	end

	// Mirrors the protection state on a pin.
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_protected <= 1'b0;
		end else begin
			o_protected <= protect_on;
		end
	end

	// External readout answers one cycle later, or is refused when protected.
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_ext_rdata <= 8'h00;
			o_ext_refused <= 1'b0;
		end else if (i_ext_rd && protect_on) begin
			o_ext_rdata <= 8'h00;
			o_ext_refused <= 1'b1;
		end else if (i_ext_rd) begin
			o_ext_rdata <= prog_mem[i_ext_addr];
			o_ext_refused <= 1'b0;
		end else begin
			o_ext_refused <= 1'b0;
		end
	end

	// Instruction fetch uses the program counter on its own port only.
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_fetch_data <= 8'h00;
		end else begin
			o_fetch_data <= prog_mem[i_program_counter];
		end
	end

	// ----------------------------------------
	// Stack space
	// ----------------------------------------

	// Push shifts every level down; pop shifts up and the deepest level stays.
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			for (int i = 0; i < `MSD_STACK_LEVELS; i++) begin
				stack_lvl[i] <= 12'h000;
			end
		end else if (i_stack_push) begin
			stack_lvl[0] <= i_push_addr;
			for (int i = 1; i < `MSD_STACK_LEVELS; i++) begin
				stack_lvl[i] <= stack_lvl[i - 1];
			end
		end else if (i_stack_pop) begin
			for (int i = 0; i < `MSD_STACK_LEVELS - 1; i++) begin
				stack_lvl[i] <= stack_lvl[i + 1];
			end
		end
	end

	// Presents the newest return address.
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_stack_top <= 12'h000;
		end else if (i_stack_push) begin
			o_stack_top <= i_push_addr;
		end else if (i_stack_pop) begin
			o_stack_top <= stack_lvl[1];
		end
	end

	// ----------------------------------------
	// Data-space registers without reset
	// ----------------------------------------

	// User RAM is written only inside its range.
	always_ff @(posedge i_ref_clk) begin
		if (wr && region == MSD_REG_RAM) begin
			data_ram[ram_idx] <= i_data_req.wdata;
		end
	end

	// Core registers keep no reset value.
	always_ff @(posedge i_ref_clk) begin
		if (wr) begin
			case (i_data_req.addr)
				`MSD_PTR_ONE: pointer_reg_one <= i_data_req.wdata;
				`MSD_PTR_TWO: pointer_reg_two <= i_data_req.wdata;
				`MSD_SHORT_ONE: short_direct_one <= i_data_req.wdata;
				`MSD_SHORT_TWO: short_direct_second <= i_data_req.wdata;
				`MSD_ACC: accumulator <= i_data_req.wdata;
				`MSD_WIN_SEL: rom_window_select <= i_data_req.wdata;
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// Data-space registers with reset, except the interrupt option
	// ----------------------------------------

	// Port registers, all cleared at reset.
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_port_a <= '{level: `MSD_PORT_RST, dir: `MSD_PORT_RST};
			o_port_b <= '{level: `MSD_PORT_RST, dir: `MSD_PORT_RST};
			o_port_a_option <= `MSD_PORT_RST;
			o_port_b_option <= `MSD_PORT_RST;
		end else if (wr) begin
			case (i_data_req.addr)
				`MSD_PA_DATA: o_port_a.level <= i_data_req.wdata;
				`MSD_PB_DATA: o_port_b.level <= i_data_req.wdata;
				`MSD_PA_DIR: o_port_a.dir <= i_data_req.wdata;
				`MSD_PB_DIR: o_port_b.dir <= i_data_req.wdata;
				`MSD_PA_OPT: o_port_a_option <= i_data_req.wdata;
				`MSD_PB_OPT: o_port_b_option <= i_data_req.wdata;
				default: begin
				end
			endcase
		end
	end

	// Interrupt option has no reset value and is only ever written.
	always_ff @(posedge i_ref_clk) begin
		if (wr && i_data_req.addr == `MSD_INT_OPT) begin
			o_interrupt_option <= i_data_req.wdata;
		end
	end

	// Converter control: software writes the low bits, hardware loads the high bits.
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_conv_control <= `MSD_CONV_CTRL_RST;
		end else begin
			if (wr && i_data_req.addr == `MSD_CONV_CTRL) begin
				o_conv_control[5:0] <= i_data_req.wdata[5:0];
			end
			if (i_conv_status_we) begin
				o_conv_control[7:6] <= i_conv_status[7:6];
			end
		end
	end

	// Timer and watchdog registers.
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_timer_prescaler <= `MSD_TMR_PRE_RST;
			o_timer_downcounter <= `MSD_TMR_CNT_RST;
			o_timer_status_control <= `MSD_TMR_SC_RST;
			o_watchdog_reg <= `MSD_WDG_RST;
		end else if (wr) begin
			case (i_data_req.addr)
				`MSD_TMR_PRE: o_timer_prescaler <= i_data_req.wdata;
				`MSD_TMR_CNT: o_timer_downcounter <= i_data_req.wdata;
				`MSD_TMR_SC: o_timer_status_control <= i_data_req.wdata;
				`MSD_WDG: o_watchdog_reg <= i_data_req.wdata;
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------

	// Combined read value for the current address.
	logic [7:0] next_rdata;
	// Hardware register read value.
	logic [7:0] hw_rdata;

	// Hardware registers; write-only locations and holes read as FFh.
	always_comb begin
		case (i_data_req.addr)
			`MSD_PTR_ONE: hw_rdata = pointer_reg_one;
			`MSD_PTR_TWO: hw_rdata = pointer_reg_two;
			`MSD_SHORT_ONE: hw_rdata = short_direct_one;
			`MSD_SHORT_TWO: hw_rdata = short_direct_second;
			`MSD_PA_DATA: begin
				hw_rdata = (o_port_a.level & o_port_a.dir) | (i_port_a_pin & ~o_port_a.dir);
			end
			`MSD_PB_DATA: begin
				hw_rdata = (o_port_b.level & o_port_b.dir) | (i_port_b_pin & ~o_port_b.dir);
			end
			`MSD_PA_DIR: hw_rdata = o_port_a.dir;
			`MSD_PB_DIR: hw_rdata = o_port_b.dir;
			`MSD_PA_OPT: hw_rdata = o_port_a_option;
			`MSD_PB_OPT: hw_rdata = o_port_b_option;
			`MSD_CONV_RES: hw_rdata = i_conv_result;
			`MSD_CONV_CTRL: hw_rdata = o_conv_control & `MSD_CONV_RO_MASK;
			`MSD_TMR_PRE: hw_rdata = o_timer_prescaler;
			`MSD_TMR_CNT: hw_rdata = o_timer_downcounter;
			`MSD_TMR_SC: hw_rdata = o_timer_status_control;
			`MSD_WDG: hw_rdata = o_watchdog_reg;
			`MSD_ACC: hw_rdata = accumulator;
			default: hw_rdata = `MSD_RSVD_READ;
		endcase
	end

	// Chooses the read source by region.
	always_comb begin
		case (region)
			MSD_REG_WINDOW: next_rdata = prog_mem[win_addr];
			MSD_REG_RAM: next_rdata = data_ram[ram_idx];
			MSD_REG_HW: next_rdata = hw_rdata;
			default: next_rdata = `MSD_RSVD_READ;
		endcase
	end

	// Read data is registered and answers the cycle after the read strobe.
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_data_rdata <= 8'h00;
		end else if (i_data_req.rd) begin
			o_data_rdata <= next_rdata;
		end
	end

endmodule

// *** rtl/msd_defs.svh ***
`ifndef MSD_DEFS_SVH
`define MSD_DEFS_SVH

// ----------------------------------------
// Data-space offsets
// ----------------------------------------
`define MSD_WIN_LO 8'h40
`define MSD_WIN_HI 8'h7F
`define MSD_PTR_ONE 8'h80
`define MSD_PTR_TWO 8'h81
`define MSD_SHORT_ONE 8'h82
`define MSD_SHORT_TWO 8'h83
`define MSD_RAM_LO 8'h84
`define MSD_RAM_HI 8'hBF
`define MSD_PA_DATA 8'hC0
`define MSD_PB_DATA 8'hC1
`define MSD_PA_DIR 8'hC4
`define MSD_PB_DIR 8'hC5
`define MSD_INT_OPT 8'hC8
`define MSD_WIN_SEL 8'hC9
`define MSD_PA_OPT 8'hCC
`define MSD_PB_OPT 8'hCD
`define MSD_CONV_RES 8'hD0
`define MSD_CONV_CTRL 8'hD1
`define MSD_TMR_PRE 8'hD2
`define MSD_TMR_CNT 8'hD3
`define MSD_TMR_SC 8'hD4
`define MSD_WDG 8'hD8
`define MSD_ACC 8'hFF

// ----------------------------------------
// Reset values, field layouts and sizes
// ----------------------------------------
`define MSD_PORT_RST 8'h00
`define MSD_CONV_CTRL_RST 8'h40
`define MSD_TMR_PRE_RST 8'h7F
`define MSD_TMR_CNT_RST 8'hFF
`define MSD_TMR_SC_RST 8'h00
`define MSD_WDG_RST 8'hFE
`define MSD_CONV_RO_MASK 8'hC0
`define MSD_CONV_WO_MASK 8'h3F
`define MSD_RSVD_READ 8'hFF
`define MSD_ERASED 8'hFF
`define MSD_PM_DEPTH 4096
`define MSD_RAM_DEPTH 60
`define MSD_STACK_LEVELS 6

`endif

// *** rtl/msd_pkg.sv ***
// ----------------------------------------
// Shared types of the memory space decoder
// ----------------------------------------
package msd_pkg;

	// One core access to the data space.
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} msd_data_req_t;

	// One port's pin-side view: output level and direction.
	typedef struct packed {
		logic [7:0] level;
		logic [7:0] dir;
	} msd_port_out_t;

	// Region selected by a data-space address.
	typedef enum logic [1:0] {
		MSD_REG_WINDOW,
		MSD_REG_RAM,
		MSD_REG_HW,
		MSD_REG_NONE
	} msd_region_t;

endpackage

// *** verification/msd_decoder_properties.sv ***
// ----------------------------------------
// Port-level checker of the decoder
// ----------------------------------------
module msd_checker
	import msd_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire msd_data_req_t i_data_req,
	input wire logic [7:0] o_data_rdata,
	input wire logic i_stack_push,
	input wire logic [11:0] i_push_addr,
	input wire logic [11:0] o_stack_top,
	input wire logic i_full_erase,
	input wire logic i_ext_rd,
	input wire logic [7:0] o_ext_rdata,
	input wire logic o_ext_refused,
	input wire logic o_protected,
	input wire logic [7:0] i_port_b_pin,
	input wire msd_port_out_t o_port_a,
	input wire msd_port_out_t o_port_b,
	input wire logic [7:0] o_port_a_option,
	input wire logic [7:0] o_timer_prescaler,
	input wire logic [7:0] o_timer_downcounter,
	input wire logic [7:0] o_conv_control
);
	timeunit 1ns;
	timeprecision 100ps;

	// All checks sample on the core clock and sleep during reset.
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);

	reset_values_a: assert property ($past(i_sys_rst) |-> o_port_a == 16'h0000
		&& o_port_b == 16'h0000 && o_timer_prescaler == 8'h7F
		&& o_timer_downcounter == 8'hFF && o_conv_control == 8'h40)
		else $error("register not at its reset value");
	port_write_a: assert property (i_data_req.wr && i_data_req.addr == 8'hC0
		|=> o_port_a.level == $past(i_data_req.wdata)) else $error("port a data not written");
	dir_write_a: assert property (i_data_req.wr && i_data_req.addr == 8'hC5
		|=> o_port_b.dir == $past(i_data_req.wdata)) else $error("port b direction not written");
	option_write_a: assert property (i_data_req.wr && i_data_req.addr == 8'hCC
		|=> o_port_a_option == $past(i_data_req.wdata)) else $error("port a option not written");
	prescaler_write_a: assert property (i_data_req.wr && i_data_req.addr == 8'hD2
		|=> o_timer_prescaler == $past(i_data_req.wdata)) else $error("prescaler not written");
	pin_read_a: assert property (i_data_req.rd && i_data_req.addr == 8'hC1
		|=> o_data_rdata == (($past(o_port_b.level) & $past(o_port_b.dir))
		| ($past(i_port_b_pin) & ~$past(o_port_b.dir)))) else $error("port b read wrong");
	select_read_a: assert property (i_data_req.rd && i_data_req.addr == 8'hC9
		|=> o_data_rdata == 8'hFF) else $error("window select read back");
	conv_read_a: assert property (i_data_req.rd && i_data_req.addr == 8'hD1
		|=> o_data_rdata[5:0] == 6'h00) else $error("write-only converter bits read back");
	readout_refuse_a: assert property (i_ext_rd && o_protected
		|=> o_ext_refused && o_ext_rdata == 8'h00) else $error("protected readout not refused");
	erase_clear_a: assert property (i_full_erase |-> ##2 !o_protected)
		else $error("erase left protection on");
	protect_hold_a: assert property (o_protected && !i_full_erase && !$past(i_full_erase)
		|=> o_protected) else $error("protection dropped without erase");
	stack_push_a: assert property (i_stack_push |=> o_stack_top == $past(i_push_addr))
		else $error("pushed address not on top");

	// Main scenarios reached by the bench.
	cover property (i_ext_rd && o_protected);
	cover property (i_data_req.rd && i_data_req.addr == 8'hC1);
	cover property (i_full_erase);
endmodule

bind msd_decoder msd_checker msd_checker_inst (.*);

// *** verification/msd_core_model.sv ***
// ----------------------------------------
// Processor core side of the data space
// ----------------------------------------
module msd_core_model
	import msd_pkg::*;
(
	input wire logic i_ref_clk,
	output msd_data_req_t o_req
);
	timeunit 1ns;
	timeprecision 100ps;

	// The core is idle until asked to make an access.
	initial o_req = '0;

	// One access: request stands for exactly one clock edge, then idles.
	task automatic access(input logic r, input logic w, input logic [7:0] a, input logic [7:0] v);
		@(negedge i_ref_clk);
		o_req = '{rd: r, wr: w, addr: a, wdata: v};
		@(negedge i_ref_clk);
		o_req = '0;
	endtask
endmodule

// *** verification/testbench.sv ***
// ----------------------------------------
// Self-checking bench of the decoder
// ----------------------------------------
module testbench;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk = 1'b0;
	logic rst = 1'b1;
	msd_pkg::msd_data_req_t req;
	msd_pkg::msd_port_out_t pa_o, pb_o;
	logic [7:0] rdata, fetch, ext_d, conv_c, d, m;
	logic [7:0] pa_pin = 8'h00, pb_pin = 8'h00, conv_res = 8'h00, conv_st = 8'h00, p_wd = 8'h00;
	logic [11:0] top, pc = 12'h000, push_a = 12'h000, p_addr = 12'h000;
	logic push = 0, pop = 0, p_we = 0, prot = 0, erase = 0, e_rd = 0, st_we = 0, refused, protd;
	logic [5:0] blk, off;
	logic [7:0] exp_q[$];
	logic rd_seen = 1'b0;
	logic [7:0] rw_a[15] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'hBF, 8'hC4, 8'hC5, 8'hCC,
		8'hCD, 8'hD2, 8'hD3, 8'hD4, 8'hD8, 8'hFF};
	// Register outputs that the bench compares directly.
	logic [7:0] int_o, pb_opt, t_cnt, t_sc, wdg;
	logic [7:0] ff_a[6] = '{8'hC8, 8'hC9, 8'hC2, 8'hD5, 8'h00, 8'h3F};
	integer seed = 26, fails = 0, n_checks = 0, i;

	// ----------------------------------------
	// Clock, design and core model
	// ----------------------------------------
	initial begin
		forever #12.5 clk = ~clk;
	end

	msd_core_model msd_core_model_inst (.i_ref_clk(clk), .o_req(req));

	msd_decoder msd_decoder_inst (.i_ref_clk(clk), .i_sys_rst(rst), .i_data_req(req),
		.o_data_rdata(rdata), .i_program_counter(pc), .o_fetch_data(fetch),
		.i_stack_push(push), .i_stack_pop(pop), .i_push_addr(push_a), .o_stack_top(top),
		.i_prog_we(p_we), .i_prog_addr(p_addr), .i_prog_wdata(p_wd), .i_protect_set(prot),
		.i_full_erase(erase), .i_ext_rd(e_rd), .i_ext_addr(p_addr), .o_ext_rdata(ext_d),
		.o_ext_refused(refused), .o_protected(protd), .i_port_a_pin(pa_pin),
		.i_port_b_pin(pb_pin), .o_port_a(pa_o), .o_port_b(pb_o), .o_port_a_option(),
		.o_port_b_option(pb_opt), .o_interrupt_option(int_o), .i_conv_result(conv_res),
		.i_conv_status_we(st_we), .i_conv_status(conv_st), .o_conv_control(conv_c),
		.o_timer_prescaler(), .o_timer_downcounter(t_cnt), .o_timer_status_control(t_sc),
		.o_watchdog_reg(wdg));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	// Compares one value and counts the outcome.
	task automatic check(input logic [11:0] seen, input logic [11:0] want);
		n_checks++;
		if (seen !== want) begin
			fails++;
			$display("wrong value at %0t ns: got %h, expected %h", $time, seen, want);
		end
	endtask

	// Core access; a read notes its expected byte first.
	task automatic acc(input logic r, input logic [7:0] a, input logic [7:0] v, input logic [7:0] e);
		if (r) exp_q.push_back(e);
		msd_core_model_inst.access(r, ~r, a, v);
	endtask

	// Raises a strobe for exactly one clock edge.
	task automatic pulse(ref logic s);
		@(negedge clk) s = 1'b1;
		@(negedge clk) s = 1'b0;
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test();
		$display("checks %0d, mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Read data is compared at the falling edge half a cycle after the edge that took the read.
	always @(posedge clk) rd_seen <= req.rd;
	always @(negedge clk) begin
		if (rd_seen) check({4'h0, rdata}, {4'h0, exp_q.pop_front()});
	end

	// Cuts a hang short.
	initial begin
		#(25 * 4000);
		fails++;
		stop_test();
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		// A blank part: one full erasure under reset blanks memory and the latch.
		repeat (14) @(negedge clk);
		pulse(erase);
		rst = 1'b0;
		pa_pin = 8'($random(seed));
		pb_pin = 8'($random(seed));
		conv_res = 8'($random(seed));
		// Reset values; port pins read back because every pin is an input.
		acc(1, 8'hC0, 0, pa_pin);
		acc(1, 8'hC5, 0, 8'h00);
		acc(1, 8'hCD, 0, 8'h00);
		acc(1, 8'hD1, 0, 8'h40);
		acc(1, 8'hD2, 0, 8'h7F);
		acc(1, 8'hD3, 0, 8'hFF);
		acc(1, 8'hD4, 0, 8'h00);
		acc(1, 8'hD8, 0, 8'hFE);
		// Every read/write register and both ends of user RAM keep a random byte.
		foreach (rw_a[k]) begin
			d = 8'($random(seed));
			acc(0, rw_a[k], d, 0);
			acc(1, rw_a[k], 0, d);
		end
		// Mixed directions: outputs show the register, inputs the pins.
		for (i = 0; i < 2; i++) begin
			m = 8'($random(seed));
			d = 8'($random(seed));
			acc(0, 8'hC4 + i[7:0], m, 0);
			acc(0, 8'hC0 + i[7:0], d, 0);
			acc(1, 8'hC0 + i[7:0], 0, (d & m) | ((i == 1 ? pb_pin : pa_pin) & ~m));
		end
		check({4'h0, pb_o.level}, {4'h0, d});
		// Write-only and reserved places read FFh after a write.
		foreach (ff_a[k]) begin
			acc(0, ff_a[k], 8'($random(seed)), 0);
			acc(1, ff_a[k], 0, 8'hFF);
		end
		// Register outputs carry the last byte written to them.
		acc(0, 8'hC8, 8'hA5, 0);
		acc(0, 8'hCD, 8'h3C, 0);
		acc(0, 8'hD3, 8'h69, 0);
		acc(0, 8'hD4, 8'hC3, 0);
		acc(0, 8'hD8, 8'h96, 0);
		check({4'h0, int_o}, 12'h0A5);
		check({4'h0, pb_opt}, 12'h03C);
		check({4'h0, t_cnt}, 12'h069);
		check({4'h0, t_sc}, 12'h0C3);
		check({4'h0, wdg}, 12'h096);
		acc(0, 8'hD0, 8'h5A, 0);
		acc(1, 8'hD0, 0, conv_res);
		acc(0, 8'hD1, 8'hFF, 0);
		acc(1, 8'hD1, 0, 8'h40);
		check({4'h0, conv_c}, 12'h07F);
		conv_st = 8'h80;
		pulse(st_we);
		acc(1, 8'hD1, 0, 8'h80);
		// Window reads and fetches of random program blocks.
		for (i = 0; i < 4; i++) begin
			blk = 6'($random(seed));
			off = 6'($random(seed));
			d = 8'($random(seed));
			p_addr = {blk, off};
			p_wd = d;
			pulse(p_we);
			acc(0, 8'hC9, {2'b00, blk}, 0);
			acc(1, {2'b01, off}, 0, d);
			pc = {blk, off};
			@(negedge clk);
			check({4'h0, fetch}, {4'h0, d});
		end
		// Readout: open, refused once protected, open and blank after erase.
		pulse(e_rd);
		check({3'h0, refused, ext_d}, {4'h0, d});
		pulse(prot);
		pulse(e_rd);
		check({3'h0, refused, ext_d}, 12'h100);
		// A reset in mid-run leaves the protection standing.
		rst = 1'b1;
		@(negedge clk);
		rst = 1'b0;
		pulse(e_rd);
		check({2'h0, protd, refused, ext_d}, 12'h300);
		pulse(erase);
		@(negedge clk);
		check({11'h000, protd}, 12'h000);
		pulse(e_rd);
		check({3'h0, refused, ext_d}, 12'h0FF);
		// Stack: the newest push is on top and a pop uncovers the older one.
		push_a = 12'h123;
		pulse(push);
		push_a = 12'($random(seed));
		pulse(push);
		check(top, push_a);
		pulse(pop);
		check(top, 12'h123);
		repeat (2) @(negedge clk);
		stop_test();
	end
endmodule
